//--- rtl/nrf_pkg.sv
package nrf_pkg;

  // Bus word offsets (byte addresses, one aligned word each)
  localparam logic [7:0] OFS_WINDOW = 8'h00;
  localparam logic [7:0] OFS_BANK = 8'h04;
  localparam logic [7:0] OFS_ROWPTR = 8'h08;
  localparam logic [7:0] OFS_RFCMD = 8'h0c;
  localparam logic [7:0] OFS_DMADDR = 8'h10;
  localparam logic [7:0] OFS_DMDATA = 8'h14;
  localparam logic [7:0] OFS_ADDRREG = 8'h18;
  localparam logic [7:0] OFS_INDEXREG = 8'h1c;
  localparam logic [7:0] OFS_INCR = 8'h20;
  // Working row window: 16 words from here
  localparam logic [1:0] OFS_ROW_TOP = 2'h1;

  // Register file layout
  localparam int RF_AW = 7;
  localparam int RF_OP_BIT = 7;
  localparam logic [6:0] RF_WINDOW_ADDR = 7'h78;
  localparam int INCR_AR_BIT = 0;
  localparam int INCR_IX_BIT = 1;

  // Valid-bit masks, fixed-zero bits are cleared
  localparam logic [3:0] BANK_MASK = 4'h1;
  localparam logic [3:0] ROWPTR_MASK = 4'hf;
  localparam logic [15:0] AR_MASK = 16'h03ff;
  localparam logic [11:0] IX_MASK = 12'h7ff;

  // Values after reset
  localparam logic [3:0] NIB_RESET = 4'h0;
  localparam logic [6:0] ADDR7_RESET = 7'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [15:0] AR_RESET = 16'h0000;
  localparam logic [11:0] IX_RESET = 12'h000;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // Bus access sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_DONE = 2'b11
  } nrf_state_type;

  // Implemented control entries
  function automatic logic ctrl_impl(input logic [5:0] idx);
    case (idx)
      6'h01, 6'h02, 6'h03, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0f,
      6'h11, 6'h12, 6'h13, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1f,
      6'h20, 6'h21, 6'h22, 6'h23, 6'h27, 6'h2f, 6'h37, 6'h3f: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Read-only control entries
  function automatic logic ctrl_ro(input logic [5:0] idx);
    case (idx)
      6'h0f, 6'h1f, 6'h2f, 6'h3f: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Implemented bit positions per entry
  function automatic logic [3:0] ctrl_bits(input logic [5:0] idx);
    case (idx)
      6'h01: return 4'h7;
      6'h07: return 4'h3;
      default: return 4'hf;
    endcase
  endfunction

  // Action bits: writable, always read zero
  function automatic logic [3:0] ctrl_action(input logic [5:0] idx);
    case (idx)
      6'h03: return 4'h9;
      6'h11, 6'h12, 6'h13: return 4'h4;
      6'h20: return 4'h1;
      default: return 4'h0;
    endcase
  endfunction

endpackage

//--- rtl/nrf_ctrl_area.sv
`timescale 1ns/1ps
module nrf_ctrl_area (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Access port
  input wire logic wrEn,
  input wire logic [5:0] addr,
  input wire logic [3:0] wrData,
  output logic [3:0] rdData,
  // Peripheral side
  input wire logic [255:0] statusIn,
  output logic [255:0] ctrlOut,
  output logic [255:0] actionPulse
);

  // Read value of every entry
  logic [255:0] readVec;

  // One slice per control entry
  for (genvar i = 0; i < 64; i++) begin : g_entry
    localparam logic [5:0] IDX = 6'(i);
    localparam logic [3:0] BITS = nrf_pkg::ctrl_bits(IDX);
    localparam logic [3:0] ACT = nrf_pkg::ctrl_action(IDX);
    wire hit = wrEn && (addr == IDX);
    if (nrf_pkg::ctrl_impl(IDX) && !nrf_pkg::ctrl_ro(IDX)) begin : g_rw
      logic [3:0] store_r;
      logic [3:0] pulse_r;
      // Fixed-zero bits never stored
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          store_r <= nrf_pkg::NIB_RESET;
          pulse_r <= nrf_pkg::NIB_RESET;
        end else begin
          if (hit) begin
            store_r <= wrData & BITS & ~ACT;
          end
          pulse_r <= hit ? (wrData & ACT) : nrf_pkg::NIB_RESET;
        end
      end
      // Action bits are strobes, so they read back zero
      assign readVec[i*4 +: 4] = store_r;
      assign ctrlOut[i*4 +: 4] = store_r;
      assign actionPulse[i*4 +: 4] = pulse_r;
    end else if (nrf_pkg::ctrl_impl(IDX)) begin : g_ro
      // Status seen live, writes dropped
      assign readVec[i*4 +: 4] = statusIn[i*4 +: 4] & BITS;
      assign ctrlOut[i*4 +: 4] = 4'h0;
      assign actionPulse[i*4 +: 4] = 4'h0;
    end else begin : g_none
      // Unimplemented: no storage, reads zero
      assign readVec[i*4 +: 4] = 4'h0;
      assign ctrlOut[i*4 +: 4] = 4'h0;
      assign actionPulse[i*4 +: 4] = 4'h0;
    end
  end

  // Read select
  assign rdData = readVec[{addr, 2'b00} +: 4];

endmodule

//--- rtl/nrf_data_mem.sv
`timescale 1ns/1ps
module nrf_data_mem (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Single port: bank bit, row, column
  input wire logic [7:0] addr,
  input wire logic wrEn,
  input wire logic [3:0] wrData,
  output logic [3:0] rdData
);

  // Two banks of 128 nibbles
  logic [3:0] cells [0:255];
  logic [3:0] rdData_r;

  // Contents are not reset, like real RAM
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      cells[addr] <= wrData;
    end
  end

  // Registered read, one cycle after the address
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdData_r <= nrf_pkg::NIB_RESET;
    end else begin
      rdData_r <= cells[addr];
    end
  end

  assign rdData = rdData_r;

endmodule

//--- rtl/nrf_register_file.sv
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module nrf_register_file (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Peripheral control area
  input wire logic [255:0] ctrlStatusIn,
  output logic [255:0] ctrlOut,
  output logic [255:0] ctrlActionPulse,
  // Core-visible state
  output logic [3:0] windowValue,
  output logic bankSel
);

  // Sequencer state
  nrf_pkg::nrf_state_type state_r;
  nrf_pkg::nrf_state_type state_nxt;

  // Software-visible registers
  logic [3:0] window_r; // Window register
  logic [3:0] bank_r; // Current bank, only bit 0 valid
  logic [3:0] rowPtr_r; // Bank in bit 3, row in bits 2:0
  logic [7:0] lastCmd_r; // Last file operation issued
  logic [6:0] dmAddr_r; // Ordinary data access address
  logic [15:0] addrReg_r; // Address register
  logic [11:0] indexReg_r; // Index register
  logic [31:0] readData_r; // Read answer held for the bus

  // Register next values
  logic [3:0] window_nxt;
  logic [15:0] addrReg_nxt;
  logic [11:0] indexReg_nxt;

  // Request decode
  wire req = avs_read || avs_write;
  wire commit = req && (state_r == nrf_pkg::ST_DONE);
  wire wrCommit = commit && avs_write;
  wire be0 = avs_byteenable[0];
  wire be1 = avs_byteenable[1];
  wire hitWindow = (avs_address == nrf_pkg::OFS_WINDOW);
  wire hitBank = (avs_address == nrf_pkg::OFS_BANK);
  wire hitRowPtr = (avs_address == nrf_pkg::OFS_ROWPTR);
  wire hitRfCmd = (avs_address == nrf_pkg::OFS_RFCMD);
  wire hitDmAddr = (avs_address == nrf_pkg::OFS_DMADDR);
  wire hitDmData = (avs_address == nrf_pkg::OFS_DMDATA);
  wire hitAddrReg = (avs_address == nrf_pkg::OFS_ADDRREG);
  wire hitIndexReg = (avs_address == nrf_pkg::OFS_INDEXREG);
  wire hitIncr = (avs_address == nrf_pkg::OFS_INCR);
  wire hitRow = (avs_address[7:6] == nrf_pkg::OFS_ROW_TOP) && (avs_address[1:0] == 2'b00);
  wire [3:0] rowCol = avs_address[5:2];

  // File operation fields, taken from the command word
  wire [6:0] rfAddr = avs_writedata[6:0];
  wire rfIsWrite = avs_writedata[nrf_pkg::RF_OP_BIT];
  wire rfUpper = rfAddr[6];
  wire rfCmdGo = hitRfCmd && avs_write && be0;

  // Memory address select: file alias, ordinary access, working row
  logic [7:0] memAddr;
  assign memAddr = rfCmdGo ? {bank_r[0], rfAddr} :
                   hitDmData ? {bank_r[0], dmAddr_r} :
                   {rowPtr_r[3], rowPtr_r[2:0], rowCol};

  // Memory path in use for this request
  wire memPath = (rfCmdGo && rfUpper) || hitDmData || hitRow;
  // The window itself sits at 78H in each bank, so steer it there
  wire winAlias = memPath && (memAddr[6:0] == nrf_pkg::RF_WINDOW_ADDR);

  // Data read from the memory array and the control area
  logic [3:0] memRd;
  logic [3:0] ctrlRd;
  wire [3:0] memNib = winAlias ? window_r : memRd;
  // Low half comes only from the control area
  wire [3:0] rfReadNib = rfUpper ? memNib : ctrlRd;

  // Write strobes for the two stores
  wire rfWrCommit = wrCommit && rfCmdGo && rfIsWrite;
  wire rfRdCommit = wrCommit && rfCmdGo && !rfIsWrite;
  wire memWrEn = !winAlias && ((rfWrCommit && rfUpper) ||
                 (wrCommit && be0 && (hitDmData || hitRow)));
  wire ctrlWrEn = rfWrCommit && !rfUpper;
  // File writes carry the window, other writes the bus nibble
  wire [3:0] memWrData = rfCmdGo ? window_r : avs_writedata[3:0];

  // Peripheral control storage
  nrf_ctrl_area u_ctrl (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .wrEn(ctrlWrEn),
    .addr(rfAddr[5:0]),
    .wrData(window_r),
    .rdData(ctrlRd),
    .statusIn(ctrlStatusIn),
    .ctrlOut(ctrlOut),
    .actionPulse(ctrlActionPulse)
  );

  // Data memory, both banks
  nrf_data_mem u_mem (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .addr(memAddr),
    .wrEn(memWrEn),
    .wrData(memWrData),
    .rdData(memRd)
  );

  // Increment with wrap over valid bits only
  wire incAr = wrCommit && hitIncr && be0 && avs_writedata[nrf_pkg::INCR_AR_BIT];
  wire incIx = wrCommit && hitIncr && be0 && avs_writedata[nrf_pkg::INCR_IX_BIT];
  // Forcing fixed bits to one lets the carry skip them
  wire [15:0] arInc = ((addrReg_r | ~nrf_pkg::AR_MASK) + 16'h0001) & nrf_pkg::AR_MASK;
  wire [11:0] ixInc = ((indexReg_r | ~nrf_pkg::IX_MASK) + 12'h001) & nrf_pkg::IX_MASK;
  wire [15:0] arWrite = {be1 ? avs_writedata[15:8] : addrReg_r[15:8],
                         be0 ? avs_writedata[7:0] : addrReg_r[7:0]};
  wire [11:0] ixWrite = {be1 ? avs_writedata[11:8] : indexReg_r[11:8],
                         be0 ? avs_writedata[7:0] : indexReg_r[7:0]};

  // Address register next value
  always_comb begin
    addrReg_nxt = addrReg_r;
    if (incAr) begin
      addrReg_nxt = arInc;
    end else if (wrCommit && hitAddrReg) begin
      addrReg_nxt = arWrite & nrf_pkg::AR_MASK;
    end
  end

  // Index register next value
  always_comb begin
    indexReg_nxt = indexReg_r;
    if (incIx) begin
      indexReg_nxt = ixInc;
    end else if (wrCommit && hitIndexReg) begin
      indexReg_nxt = ixWrite & nrf_pkg::IX_MASK;
    end
  end

  // Window next value; every file read lands here
  always_comb begin
    window_nxt = window_r;
    if (rfRdCommit) begin
      window_nxt = rfReadNib;
    end else if (wrCommit && be0 && (hitWindow || winAlias)) begin
      window_nxt = avs_writedata[3:0];
    end
  end

  // Read answer select
  logic [31:0] rdValue;
  always_comb begin
    rdValue = nrf_pkg::WORD_RESET;
    if (hitWindow) begin
      rdValue = {28'h0, window_r};
    end else if (hitBank) begin
      rdValue = {28'h0, bank_r};
    end else if (hitRowPtr) begin
      rdValue = {28'h0, rowPtr_r};
    end else if (hitRfCmd) begin
      rdValue = {24'h0, lastCmd_r};
    end else if (hitDmAddr) begin
      rdValue = {25'h0, dmAddr_r};
    end else if (hitDmData || hitRow) begin
      rdValue = {28'h0, memNib};
    end else if (hitAddrReg) begin
      rdValue = {16'h0, addrReg_r};
    end else if (hitIndexReg) begin
      rdValue = {20'h0, indexReg_r};
    end
  end

  // Sequencer: take, let memory settle, answer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      nrf_pkg::ST_IDLE: begin
        if (req) begin
          state_nxt = nrf_pkg::ST_EXEC;
        end
      end
      nrf_pkg::ST_EXEC: begin
        state_nxt = nrf_pkg::ST_DONE;
      end
      nrf_pkg::ST_DONE: begin
        state_nxt = nrf_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = nrf_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer and read answer flops
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= nrf_pkg::ST_IDLE;
      readData_r <= nrf_pkg::WORD_RESET;
    end else begin
      state_r <= state_nxt;
      // Memory read data is valid by EXEC
      if (state_r == nrf_pkg::ST_EXEC && avs_read) begin
        readData_r <= rdValue;
      end
    end
  end

  // Window, address and index registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      window_r <= nrf_pkg::NIB_RESET;
      addrReg_r <= nrf_pkg::AR_RESET;
      indexReg_r <= nrf_pkg::IX_RESET;
    end else begin
      window_r <= window_nxt;
      addrReg_r <= addrReg_nxt;
      indexReg_r <= indexReg_nxt;
    end
  end

  // Bank, row pointer, data address and last command
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank_r <= nrf_pkg::NIB_RESET;
      rowPtr_r <= nrf_pkg::NIB_RESET;
      dmAddr_r <= nrf_pkg::ADDR7_RESET;
      lastCmd_r <= nrf_pkg::CMD_RESET;
    end else if (wrCommit && be0) begin
      if (hitBank) begin
        bank_r <= avs_writedata[3:0] & nrf_pkg::BANK_MASK;
      end
      if (hitRowPtr) begin
        // Any row may be named; unbuilt rows are software's concern
        rowPtr_r <= avs_writedata[3:0] & nrf_pkg::ROWPTR_MASK;
      end
      if (hitDmAddr) begin
        dmAddr_r <= avs_writedata[6:0];
      end
      if (hitRfCmd) begin
        lastCmd_r <= avs_writedata[7:0];
      end
    end
  end

  // Bus outputs; unmapped words answer zero and ignore writes
  assign avs_waitrequest = req && (state_r != nrf_pkg::ST_DONE);
  assign avs_readdata = readData_r;
  assign windowValue = window_r;
  assign bankSel = bank_r[0];

endmodule

//--- verif/nrf_register_file_props.sv
`timescale 1ns/1ps
module nrf_register_file_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Control area
  input wire logic [255:0] ctrlStatusIn,
  input wire logic [255:0] ctrlOut,
  input wire logic [255:0] ctrlActionPulse,
  // Core-visible state
  input wire logic [3:0] windowValue,
  input wire logic bankSel
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);
  // Transfers accepted in this cycle
  wire logic wrDone = avs_write && !avs_waitrequest;
  wire logic rdDone = avs_read && !avs_waitrequest;
  wire logic winHit = avs_address == nrf_pkg::OFS_WINDOW;
  wire logic cmdWr = wrDone && avs_address == nrf_pkg::OFS_RFCMD;
  // File write command, the only path into the control area
  wire logic ctrlWr = cmdWr && avs_writedata[nrf_pkg::RF_OP_BIT];

  answer_timing_a: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after two wait cycles");
  window_write_a: assert property (
    wrDone && winHit && avs_byteenable[0] |=> windowValue == $past(avs_writedata[3:0]))
    else $error("window write lost");
  window_read_a: assert property (
    rdDone && winHit |-> avs_readdata == {28'h0, windowValue})
    else $error("window read mismatch");
  bank_zero_a: assert property (
    rdDone && avs_address == nrf_pkg::OFS_BANK |-> avs_readdata == {31'h0, bankSel})
    else $error("bank fixed-zero bits not zero");
  window_cause_a: assert property (
    !$stable(windowValue) |-> $past(wrDone))
    else $error("window changed without a write");
  ctrl_cause_a: assert property (
    !$stable(ctrlOut) |-> $past(ctrlWr))
    else $error("control area changed without file write");
  pulse_cause_a: assert property (
    |ctrlActionPulse |-> $past(ctrlWr))
    else $error("action pulse without file write");
  ro_entry_zero_a: assert property (
    ctrlOut[63:60] == 4'h0 && ctrlOut[255:252] == 4'h0)
    else $error("read-only entry holds written value");
  unbuilt_bits_a: assert property (
    ctrlOut[7] == 1'b0 && ctrlOut[31:30] == 2'h0 && ctrlOut[3:0] == 4'h0)
    else $error("unbuilt control bits set");

  // Main scenarios reached
  cover property (rdDone && avs_address == nrf_pkg::OFS_DMDATA);
  cover property (|ctrlActionPulse);
  cover property (wrDone && avs_address == nrf_pkg::OFS_INCR);
endmodule

//--- verif/nrf_periph_model.sv
`timescale 1ns/1ps
module nrf_periph_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control area side
  input wire logic [255:0] ctrlActionPulse,
  output logic [255:0] ctrlStatusIn,
  output logic [7:0] pulseCount
);
  // Churning filler so a leak from a non-status nibble shows
  logic [3:0] churn_r;
  logic [7:0] pulse_r;
  assign pulseCount = pulse_r;
  // Status entries hold still, everything else churns
  always_comb begin
    ctrlStatusIn = {64{churn_r}};
    ctrlStatusIn[63:60] = 4'h5;
    ctrlStatusIn[127:124] = 4'ha;
    ctrlStatusIn[191:188] = 4'h3;
    ctrlStatusIn[255:252] = 4'hc;
  end
  // Count every action bit seen, one count per set bit
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      churn_r <= 4'h0;
      pulse_r <= 8'h00;
    end else begin
      churn_r <= churn_r + 4'h1;
      pulse_r <= pulse_r + 8'($countones(ctrlActionPulse));
    end
  end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  // Clock, reset and master side of the bus
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, bankSel;
  logic [7:0] pulseCount;
  logic [31:0] avs_readdata, rdq;
  logic [3:0] windowValue;
  logic [255:0] ctrlStatusIn, ctrlOut, ctrlActionPulse, snap;
  int fails, n_checks, i;
  logic [3:0] r;
  // Control entries and their value after writing all ones
  logic [6:0] entAddr [8] = '{7'h01, 7'h07, 7'h03, 7'h11, 7'h12, 7'h13, 7'h20, 7'h02};
  logic [3:0] entVal [8] = '{4'h7, 4'h3, 4'h6, 4'hb, 4'hb, 4'hb, 4'he, 4'hf};
  // Status the peripheral model shows on read-only entries
  logic [3:0] roVal [4] = '{4'h5, 4'ha, 4'h3, 4'hc};

  nrf_register_file dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ctrlStatusIn(ctrlStatusIn), .ctrlOut(ctrlOut),
    .ctrlActionPulse(ctrlActionPulse), .windowValue(windowValue), .bankSel(bankSel));
  nrf_periph_model periph (
    .core_clk(core_clk), .sys_rst(sys_rst), .ctrlActionPulse(ctrlActionPulse),
    .ctrlStatusIn(ctrlStatusIn), .pulseCount(pulseCount));

  // Free-running 100 MHz clock
  initial begin
    forever #5 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] exp, got, input string nm);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus transfer; request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    // Sampled at the rising edge, before that edge's updates land
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    chk(32'h0, {31'h0, avs_waitrequest}, "waitrequest");
    rdq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    acc(1'b0, a, 32'h0);
    chk(exp, rdq, nm);
  endtask

  // File ops always go through the window
  task automatic fwr(input logic [6:0] ra, input logic [3:0] v);
    wr(nrf_pkg::OFS_WINDOW, {28'h0, v});
    wr(nrf_pkg::OFS_RFCMD, {24'h0, 1'b1, ra});
  endtask

  task automatic frd(input logic [6:0] ra, input logic [3:0] exp, input string nm);
    wr(nrf_pkg::OFS_RFCMD, {24'h0, 1'b0, ra});
    rdchk(nrf_pkg::OFS_WINDOW, {28'h0, exp}, nm);
  endtask

  // Plain data memory access in a chosen bank
  task automatic dmw(input logic b, input logic [6:0] a, input logic [3:0] v);
    wr(nrf_pkg::OFS_BANK, {31'h0, b});
    wr(nrf_pkg::OFS_DMADDR, {25'h0, a});
    wr(nrf_pkg::OFS_DMDATA, {28'h0, v});
  endtask

  task automatic dmr(input logic b, input logic [6:0] a, input logic [3:0] exp);
    wr(nrf_pkg::OFS_BANK, {31'h0, b});
    wr(nrf_pkg::OFS_DMADDR, {25'h0, a});
    rdchk(nrf_pkg::OFS_DMDATA, {28'h0, exp}, "data memory");
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    wr(nrf_pkg::OFS_BANK, 32'hf);
    rdchk(nrf_pkg::OFS_BANK, 32'h1, "bank");
    wr(nrf_pkg::OFS_WINDOW, 32'hff);
    rdchk(nrf_pkg::OFS_WINDOW, 32'hf, "window");
    wr(nrf_pkg::OFS_ADDRREG, 32'hffff);
    rdchk(nrf_pkg::OFS_ADDRREG, 32'h3ff, "addr_reg");
    wr(8'h30, 32'h5);
    rdchk(8'h30, 32'h0, "unmapped");
    $display("test fixed bits done");
    // All valid bits set, increment wraps to zero
    wr(nrf_pkg::OFS_INCR, 32'h1);
    rdchk(nrf_pkg::OFS_ADDRREG, 32'h0, "addr_reg wrap");
    wr(nrf_pkg::OFS_INDEXREG, 32'hfff);
    wr(nrf_pkg::OFS_INCR, 32'h2);
    rdchk(nrf_pkg::OFS_INDEXREG, 32'h0, "index_reg wrap");
    wr(nrf_pkg::OFS_INCR, 32'h3);
    rdchk(nrf_pkg::OFS_ADDRREG, 32'h1, "addr_reg step");
    rdchk(nrf_pkg::OFS_INDEXREG, 32'h1, "index_reg step");
    $display("test increment done");
    // Working row in every bank-zero row, column 3
    for (r = 4'h0; r < 4'h8; r++) begin
      wr(nrf_pkg::OFS_ROWPTR, {28'h0, r});
      wr(8'h4c, {28'h0, r + 4'h1});
    end
    for (r = 4'h0; r < 4'h8; r++)
      dmr(1'b0, {r[2:0], 4'h3}, r + 4'h1);
    // Row 7 of bank one, kept apart from row 7 of bank zero
    wr(nrf_pkg::OFS_ROWPTR, 32'hf);
    wr(8'h4c, 32'h9);
    dmr(1'b1, 7'h73, 4'h9);
    dmr(1'b0, 7'h73, 4'h8);
    $display("test working row done");
    // Upper half follows the current bank
    dmw(1'b0, 7'h45, 4'ha);
    dmw(1'b1, 7'h45, 4'h5);
    dmw(1'b0, 7'h46, 4'hc);
    frd(7'h45, 4'ha, "alias bank_zero");
    wr(nrf_pkg::OFS_BANK, 32'h1);
    frd(7'h45, 4'h5, "alias bank_one");
    fwr(7'h46, 4'h3);
    dmr(1'b1, 7'h46, 4'h3);
    dmr(1'b0, 7'h46, 4'hc);
    // Control area is apart from low data memory
    fwr(7'h02, 4'h9);
    dmw(1'b0, 7'h02, 4'h6);
    frd(7'h02, 4'h9, "ctrl 02");
    dmr(1'b0, 7'h02, 4'h6);
    $display("test alias done");
    for (i = 0; i < 8; i++) begin
      fwr(entAddr[i], 4'hf);
      frd(entAddr[i], entVal[i], "ctrl entry");
    end
    chk(32'd6, {24'h0, pulseCount}, "action pulses");
    // Writes to status entries are dropped
    for (i = 0; i < 4; i++) begin
      fwr(7'(i * 16 + 15), ~roVal[i]);
      frd(7'(i * 16 + 15), roVal[i], "status entry");
    end
    snap = ctrlOut;
    fwr(7'h00, 4'hf);
    fwr(7'h3e, 4'hf);
    chk(32'h1, {31'h0, ctrlOut === snap}, "unbuilt entry");
    $display("test control area done");
    close_out();
  end
endmodule

bind nrf_register_file nrf_register_file_props props (
  .core_clk(core_clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .ctrlStatusIn(ctrlStatusIn), .ctrlOut(ctrlOut),
  .ctrlActionPulse(ctrlActionPulse), .windowValue(windowValue), .bankSel(bankSel));
